// [core/ams_top.sv]
// normal-mode async memory access sequencer with wishbone register slave
// Function
// - set bit enables wait-rise interrupt
// - set bit enables timeout interrupt
// - clear bit removes wait-rise enable
// - clear bit removes timeout enable
// - normal mode default, byte enables active
// - write enable high during reads
// - output enable high during writes
// - start when top priority, split wide requests
// - wait programmed turnaround before setup
// - same direction back to back: no turnaround
// - direction change with zero field: one cycle
// - recheck priority after turnaround, else abandon
// - read setup loads read timing fields
// - write setup loads write timing fields
// - setup drives address, asserts chip select
// - read strobe drives output enable low
// - capture read data at strobe end
// - wait input lengthens the strobe
// - hold end: address invalid, release select; select stays asserted into an extra beat or a same-direction next setup
// - extra beats reenter setup, no reload
// - pending top request goes to turnaround, or straight to setup when same direction
// - write data valid with address at setup
// - write strobe: write enable low, byte enables
// - turnaround field is the cycle count
// - timing fields are cycles minus one
// - wait beyond limit times out, flags event
// - 8-bit device takes four beats per word
//
// Implementation choices: the placing of the registers and register access over Wishbone.
module ams_top (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic CE,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic REQ_VALID,
  input wire logic REQ_TOP,
  input wire logic REQ_WRITE,
  input wire logic [1:0] REQ_CS,
  input wire logic [1:0] REQ_SIZE,
  input wire logic [23:0] REQ_ADDR,
  input wire logic [31:0] REQ_WDATA,
  output logic REQ_TAKEN,
  output logic REQ_DONE,
  output logic REQ_ABORT,
  output logic [31:0] REQ_RDATA,
  output logic [21:0] MEM_ADDR_BUS,
  output logic [1:0] MEM_BANK_ADDR_BITS,
  input wire logic [15:0] MEM_DATA_IN,
  output logic [15:0] MEM_DATA_OUT,
  output logic MEM_DATA_OE,
  output logic [2:0] ASYNC_CHIP_SELECT_N,
  output logic OUTPUT_ENABLE_N,
  output logic WRITE_ENABLE_N,
  output logic [1:0] BYTE_ENABLE_N,
  input wire logic EXT_WAIT_IN,
  output logic IRQ
);
  ams_irq_if irq_if ();
  ams_cnt_if #(.W(ams_pkg::PER_W)) per_if ();
  ams_cnt_if #(.W(ams_pkg::WCNT_W)) wcnt_if ();

  ams_irq u_irq (.clk(CLK), .resetn(RESETN), .ce(CE), .i(irq_if));
  ams_cnt u_per (.clk(CLK), .resetn(RESETN), .ce(CE), .c(per_if));
  ams_cnt u_wcnt (.clk(CLK), .resetn(RESETN), .ce(CE), .c(wcnt_if));

  // ---------------- wishbone slave ----------------
  logic ack_r;
  logic [31:0] dat_r;
  logic [31:0] rd_mux;
  logic [ams_pkg::NUM_CS-1:0][31:0] cfg_r;
  logic [8:0] wcfg_r;
  logic wb_req;
  logic wb_wr;

  assign wb_req = WB_CYC_I & WB_STB_I;
  // writes land on the edge where the master samples ack
  assign wb_wr = wb_req & ack_r & WB_WE_I;

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      ack_r <= 1'b0;
    end else if (CE) begin
      ack_r <= wb_req & ~ack_r;
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (WB_ADR_I)
      ams_pkg::OFF_CFG0: rd_mux = cfg_r[0];
      ams_pkg::OFF_CFG0 + 8'h04: rd_mux = cfg_r[1];
      ams_pkg::OFF_CFG0 + 8'h08: rd_mux = cfg_r[2];
      ams_pkg::OFF_WAIT: rd_mux = {23'h0, wcfg_r};
      ams_pkg::OFF_STAT: rd_mux = {30'h0, irq_if.status};
      ams_pkg::OFF_MSET: rd_mux = {30'h0, irq_if.mask};
      ams_pkg::OFF_MCLR: rd_mux = {30'h0, irq_if.mask};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      dat_r <= 32'h0000_0000;
    end else if (CE && wb_req && !ack_r) begin
      dat_r <= rd_mux;
    end
  end

  for (genvar c = 0; c < ams_pkg::NUM_CS; c++) begin : g_cfg
    for (genvar b = 0; b < 4; b++) begin : g_byte
      always_ff @(posedge CLK) begin
        if (!RESETN) begin
          cfg_r[c][8*b +: 8] <= ams_pkg::CFG_RST[8*b +: 8];
        end else if (CE && wb_wr && WB_SEL_I[b] && WB_ADR_I == ams_pkg::OFF_CFG0 + 8'(4 * c)) begin
          cfg_r[c][8*b +: 8] <= WB_DAT_I[8*b +: 8];
        end
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      wcfg_r <= ams_pkg::WAIT_RST;
    end else if (CE && wb_wr && WB_ADR_I == ams_pkg::OFF_WAIT) begin
      if (WB_SEL_I[0]) begin
        wcfg_r[7:0] <= WB_DAT_I[7:0];
      end
      if (WB_SEL_I[1]) begin
        wcfg_r[8] <= WB_DAT_I[8];
      end
    end
  end

  assign irq_if.set_bits = (wb_wr && WB_SEL_I[0] && WB_ADR_I == ams_pkg::OFF_MSET) ? WB_DAT_I[1:0] : 2'h0;
  assign irq_if.clr_bits = (wb_wr && WB_SEL_I[0] && WB_ADR_I == ams_pkg::OFF_MCLR) ? WB_DAT_I[1:0] : 2'h0;
  assign irq_if.ack_bits = (wb_wr && WB_SEL_I[0] && WB_ADR_I == ams_pkg::OFF_STAT) ? WB_DAT_I[1:0] : 2'h0;

  // ---------------- sequencer ----------------
  ams_pkg::ams_state_e state_r;
  ams_pkg::ams_state_e state_nxt;
  logic dir_r;
  logic [1:0] cs_r;
  logic [23:0] addr_r;
  logic [31:0] wdata_r;
  logic [31:0] rdata_r;
  logic width16_r;
  logic ew_r;
  logic [1:0] beat_r;
  logic [1:0] last_beat_r;
  logic [ams_pkg::SET_W-1:0] set_r;
  logic [ams_pkg::STB_W-1:0] stb_r;
  logic [ams_pkg::HLD_W-1:0] hld_r;
  logic last_valid_r;
  logic last_dir_r;
  logic wprev_r;
  logic start;
  logic take;
  logic abort;
  logic done;
  logic extra_beat;
  logic new_setup;
  logic wact;
  logic tmo;
  logic strobe_end;
  logic [1:0] req_cs;
  logic [31:0] req_cfg;
  logic [31:0] cfg_use;
  logic [1:0] turn_n;
  logic [1:0] beats_in;
  logic dir_nxt;
  logic [1:0] cs_nxt;
  logic [23:0] addr_nxt;
  logic [31:0] wdata_nxt;
  logic width16_nxt;
  logic [1:0] beat_nxt;
  logic [1:0] off_nxt;
  logic [1:0] off_r;
  logic [1:0] size_nxt;
  logic [1:0] size_r;
  logic [12:0] wait_max;

  // chip select code 3 is folded onto the last chip select
  assign req_cs = (REQ_CS == 2'h3) ? 2'h2 : REQ_CS;
  assign req_cfg = cfg_r[req_cs];
  assign start = REQ_VALID & REQ_TOP;

  always_comb begin
    if (last_valid_r && last_dir_r == REQ_WRITE) begin
      turn_n = 2'h0;
    end else if (last_valid_r && req_cfg[ams_pkg::F_TA +: ams_pkg::TA_W] == 2'h0) begin
      turn_n = 2'h1;
    end else begin
      turn_n = req_cfg[ams_pkg::F_TA +: ams_pkg::TA_W];
    end
  end

  // beats per request: 8-bit device splits a word into four
  always_comb begin
    beats_in = 2'h0;
    case (REQ_SIZE)
      ams_pkg::SZ_HALF: beats_in = req_cfg[ams_pkg::F_WIDTH] ? 2'h0 : 2'h1;
      ams_pkg::SZ_WORD: beats_in = req_cfg[ams_pkg::F_WIDTH] ? 2'h1 : 2'h3;
      default: beats_in = 2'h0;
    endcase
  end

  assign wact = ew_r & (wcfg_r[ams_pkg::F_WPOL] ? EXT_WAIT_IN : ~EXT_WAIT_IN);
  assign tmo = (state_r == ams_pkg::ST_STROBE) & wact & wcnt_if.zero;
  assign strobe_end = (per_if.zero & ~wact) | tmo;
  assign extra_beat = (state_r == ams_pkg::ST_HOLD) & per_if.zero & (beat_r != last_beat_r);

  always_comb begin
    state_nxt = state_r;
    take = 1'b0;
    abort = 1'b0;
    done = 1'b0;
    case (state_r)
      ams_pkg::ST_IDLE: begin
        if (start) begin
          take = 1'b1;
          state_nxt = (turn_n == 2'h0) ? ams_pkg::ST_SETUP : ams_pkg::ST_TURN;
        end
      end
      ams_pkg::ST_TURN: begin
        if (per_if.zero) begin
          if (REQ_TOP) begin
            state_nxt = ams_pkg::ST_SETUP;
          end else begin
            abort = 1'b1;
            state_nxt = ams_pkg::ST_IDLE;
          end
        end
      end
      ams_pkg::ST_SETUP: begin
        if (per_if.zero) begin
          state_nxt = ams_pkg::ST_STROBE;
        end
      end
      ams_pkg::ST_STROBE: begin
        if (strobe_end) begin
          state_nxt = ams_pkg::ST_HOLD;
        end
      end
      ams_pkg::ST_HOLD: begin
        if (extra_beat) begin
          state_nxt = ams_pkg::ST_SETUP;
        end else if (per_if.zero) begin
          done = 1'b1;
          if (start) begin
            take = 1'b1;
            state_nxt = (turn_n == 2'h0) ? ams_pkg::ST_SETUP : ams_pkg::ST_TURN;
          end else begin
            state_nxt = ams_pkg::ST_IDLE;
          end
        end
      end
      default: state_nxt = ams_pkg::ST_IDLE;
    endcase
  end

  assign dir_nxt = take ? REQ_WRITE : dir_r;
  assign cs_nxt = take ? req_cs : cs_r;
  assign addr_nxt = take ? REQ_ADDR : addr_r;
  assign wdata_nxt = take ? REQ_WDATA : wdata_r;
  assign size_nxt = take ? REQ_SIZE : size_r;
  assign width16_nxt = take ? req_cfg[ams_pkg::F_WIDTH] : width16_r;
  assign beat_nxt = take ? 2'h0 : (extra_beat ? beat_r + 2'h1 : beat_r);
  assign off_nxt = width16_nxt ? 2'(addr_nxt[1:0] + {beat_nxt[0], 1'b0}) : 2'(addr_nxt[1:0] + beat_nxt);
  assign cfg_use = cfg_r[cs_nxt];
  assign new_setup = (state_nxt == ams_pkg::ST_SETUP) & (state_r != ams_pkg::ST_SETUP) & ~extra_beat;
  assign wait_max = 13'(({1'b0, wcfg_r[ams_pkg::F_WLIM +: ams_pkg::WLIM_W]} + 9'h001) * ams_pkg::WAIT_UNIT);

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      state_r <= ams_pkg::ST_IDLE;
    end else if (CE) begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      dir_r <= 1'b0;
      cs_r <= 2'h0;
      addr_r <= 24'h00_0000;
      wdata_r <= 32'h0000_0000;
      size_r <= ams_pkg::SZ_BYTE;
      width16_r <= 1'b0;
      last_beat_r <= 2'h0;
      beat_r <= 2'h0;
      off_r <= 2'h0;
    end else if (CE) begin
      dir_r <= dir_nxt;
      cs_r <= cs_nxt;
      addr_r <= addr_nxt;
      wdata_r <= wdata_nxt;
      size_r <= size_nxt;
      width16_r <= width16_nxt;
      beat_r <= beat_nxt;
      off_r <= off_nxt;
      if (take) begin
        last_beat_r <= beats_in;
      end
    end
  end

  // timing fields are latched once per request, extra beats reuse them
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      set_r <= '0;
      stb_r <= '0;
      hld_r <= '0;
      ew_r <= 1'b0;
    end else if (CE && new_setup) begin
      ew_r <= cfg_use[ams_pkg::F_EW];
      if (dir_nxt) begin
        set_r <= cfg_use[ams_pkg::F_WSET +: ams_pkg::SET_W];
        stb_r <= cfg_use[ams_pkg::F_WSTB +: ams_pkg::STB_W];
        hld_r <= cfg_use[ams_pkg::F_WHLD +: ams_pkg::HLD_W];
      end else begin
        set_r <= cfg_use[ams_pkg::F_RSET +: ams_pkg::SET_W];
        stb_r <= cfg_use[ams_pkg::F_RSTB +: ams_pkg::STB_W];
        hld_r <= cfg_use[ams_pkg::F_RHLD +: ams_pkg::HLD_W];
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      last_valid_r <= 1'b0;
      last_dir_r <= 1'b0;
    end else if (CE && state_nxt == ams_pkg::ST_SETUP) begin
      last_valid_r <= 1'b1;
      last_dir_r <= dir_nxt;
    end
  end

  // period counter holds the timing field value, so setup, strobe and hold each last field plus one cycles
  always_comb begin
    per_if.load = (state_nxt != state_r) | extra_beat;
    per_if.dec = 1'b1;
    per_if.val = '0;
    case (state_nxt)
      ams_pkg::ST_TURN: per_if.val = ams_pkg::PER_W'(turn_n - 2'h1);
      ams_pkg::ST_SETUP: begin
        if (new_setup) begin
          per_if.val = ams_pkg::PER_W'(dir_nxt ? cfg_use[ams_pkg::F_WSET +: ams_pkg::SET_W]
                                               : cfg_use[ams_pkg::F_RSET +: ams_pkg::SET_W]);
        end else begin
          per_if.val = ams_pkg::PER_W'(set_r);
        end
      end
      ams_pkg::ST_STROBE: per_if.val = stb_r;
      ams_pkg::ST_HOLD: per_if.val = ams_pkg::PER_W'(hld_r);
      default: per_if.val = '0;
    endcase
  end

  assign wcnt_if.load = (state_nxt == ams_pkg::ST_STROBE) & (state_r != ams_pkg::ST_STROBE);
  assign wcnt_if.val = wait_max - 13'h0001;
  assign wcnt_if.dec = wact;

  // read data lanes; a timeout still captures whatever the bus carries
  for (genvar k = 0; k < 4; k++) begin : g_rd
    always_ff @(posedge CLK) begin
      if (!RESETN) begin
        rdata_r[8*k +: 8] <= 8'h00;
      end else if (CE && state_r == ams_pkg::ST_STROBE && strobe_end && !dir_r) begin
        if (width16_r && off_r[1] == 1'(k / 2)) begin
          rdata_r[8*k +: 8] <= MEM_DATA_IN[8*(k%2) +: 8];
        end else if (!width16_r && off_r == 2'(k)) begin
          rdata_r[8*k +: 8] <= MEM_DATA_IN[7:0];
        end
      end
    end
  end

  // pins are registered from the next state so they change on period edges
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      ASYNC_CHIP_SELECT_N <= 3'h7;
      OUTPUT_ENABLE_N <= 1'b1;
      WRITE_ENABLE_N <= 1'b1;
      BYTE_ENABLE_N <= 2'h3;
      MEM_DATA_OE <= 1'b0;
    end else if (CE) begin
      if (state_nxt == ams_pkg::ST_SETUP || state_nxt == ams_pkg::ST_STROBE || state_nxt == ams_pkg::ST_HOLD) begin
        ASYNC_CHIP_SELECT_N <= ~(3'h1 << cs_nxt);
        MEM_DATA_OE <= dir_nxt;
      end else begin
        ASYNC_CHIP_SELECT_N <= 3'h7;
        MEM_DATA_OE <= 1'b0;
      end
      OUTPUT_ENABLE_N <= ~(state_nxt == ams_pkg::ST_STROBE && !dir_nxt);
      WRITE_ENABLE_N <= ~(state_nxt == ams_pkg::ST_STROBE && dir_nxt);
      if ((state_nxt == ams_pkg::ST_STROBE && dir_nxt) ||
          (!dir_nxt && (state_nxt == ams_pkg::ST_SETUP || state_nxt == ams_pkg::ST_STROBE ||
                        state_nxt == ams_pkg::ST_HOLD))) begin
        if (!width16_nxt || size_nxt == ams_pkg::SZ_BYTE) begin
          BYTE_ENABLE_N <= (width16_nxt && off_nxt[0]) ? 2'h1 : 2'h2;
        end else begin
          BYTE_ENABLE_N <= 2'h0;
        end
      end else begin
        BYTE_ENABLE_N <= 2'h3;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      MEM_ADDR_BUS <= 22'h00_0000;
      MEM_BANK_ADDR_BITS <= 2'h0;
      MEM_DATA_OUT <= 16'h0000;
    end else if (CE && state_nxt == ams_pkg::ST_SETUP && state_r != ams_pkg::ST_SETUP) begin
      MEM_ADDR_BUS <= addr_nxt[23:2];
      MEM_BANK_ADDR_BITS <= width16_nxt ? {off_nxt[1], 1'b0} : off_nxt;
      if (width16_nxt) begin
        MEM_DATA_OUT <= 16'(wdata_nxt >> {off_nxt[1], 4'h0});
      end else begin
        MEM_DATA_OUT <= {8'h00, 8'(wdata_nxt >> {off_nxt, 3'h0})};
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      REQ_TAKEN <= 1'b0;
      REQ_DONE <= 1'b0;
      REQ_ABORT <= 1'b0;
      wprev_r <= 1'b1; // pin idles high, so no false rise after reset
    end else if (CE) begin
      REQ_TAKEN <= take;
      REQ_DONE <= done;
      REQ_ABORT <= abort;
      wprev_r <= EXT_WAIT_IN;
    end
  end

  assign irq_if.events[ams_pkg::IRQ_WAIT_RISE] = EXT_WAIT_IN & ~wprev_r;
  assign irq_if.events[ams_pkg::IRQ_TIMEOUT] = tmo;

  assign REQ_RDATA = rdata_r;
  assign WB_DAT_O = dat_r;
  assign WB_ACK_O = ack_r;
  assign IRQ = irq_if.irq;
endmodule : ams_top

// [inc/ams_pkg.sv]
// constants, field layout and state encoding of the async memory sequencer
package ams_pkg;
  localparam int unsigned NUM_CS = 3;
  localparam int unsigned WB_ADR_W = 8;
  localparam logic [7:0] OFF_CFG0 = 8'h00;
  localparam logic [7:0] OFF_WAIT = 8'h0C;
  localparam logic [7:0] OFF_STAT = 8'h10;
  localparam logic [7:0] OFF_MSET = 8'h14;
  localparam logic [7:0] OFF_MCLR = 8'h18;
  localparam int unsigned F_WIDTH = 0;
  localparam int unsigned F_SS = 1;
  localparam int unsigned F_EW = 2;
  localparam int unsigned F_RSET = 4;
  localparam int unsigned F_RSTB = 8;
  localparam int unsigned F_RHLD = 14;
  localparam int unsigned F_WSET = 17;
  localparam int unsigned F_WSTB = 21;
  localparam int unsigned F_WHLD = 27;
  localparam int unsigned F_TA = 30;
  localparam int unsigned SET_W = 4;
  localparam int unsigned STB_W = 6;
  localparam int unsigned HLD_W = 3;
  localparam int unsigned TA_W = 2;
  localparam int unsigned PER_W = 6;
  localparam logic [31:0] CFG_RST = 32'hFFFF_FFF0;
  localparam int unsigned F_WLIM = 0;
  localparam int unsigned WLIM_W = 8;
  localparam int unsigned F_WPOL = 8;
  localparam logic [8:0] WAIT_RST = 9'h080;
  localparam int unsigned WAIT_UNIT = 16;
  localparam int unsigned WCNT_W = 13;
  localparam int unsigned IRQ_WAIT_RISE = 0;
  localparam int unsigned IRQ_TIMEOUT = 1;
  localparam logic [1:0] MASK_RST = 2'h0;
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_HALF = 2'h1;
  localparam logic [1:0] SZ_WORD = 2'h2;
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_TURN = 5'h02,
    ST_SETUP = 5'h04,
    ST_STROBE = 5'h08,
    ST_HOLD = 5'h10
  } ams_state_e;
endpackage : ams_pkg

// [inc/ams_cnt_if.sv]
// load/decrement control of one down counter
interface ams_cnt_if #(parameter int unsigned W = 6);
  logic load;
  logic [W-1:0] val;
  logic dec;
  logic zero;
  modport ctl (output load, output val, output dec, input zero);
  modport cnt (input load, input val, input dec, output zero);
endinterface : ams_cnt_if

// [inc/ams_irq_if.sv]
// mask and event signals between the bus slave and the interrupt logic
interface ams_irq_if;
  logic [1:0] set_bits;
  logic [1:0] clr_bits;
  logic [1:0] ack_bits;
  logic [1:0] events;
  logic [1:0] mask;
  logic [1:0] status;
  logic irq;
  modport ctl (output set_bits, output clr_bits, output ack_bits, output events, input mask, input status, input irq);
  modport sink (input set_bits, input clr_bits, input ack_bits, input events, output mask, output status, output irq);
endinterface : ams_irq_if

// [core/ams_cnt.sv]
// loadable down counter that stops at zero
module ams_cnt (
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  ams_cnt_if.cnt c
);
  localparam int unsigned W = $bits(c.val);
  logic [W-1:0] cnt_r;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      cnt_r <= '0;
    end else if (ce) begin
      if (c.load) begin
        cnt_r <= c.val;
      end else if (c.dec && cnt_r != '0) begin
        cnt_r <= cnt_r - W'(1);
      end
    end
  end

  assign c.zero = (cnt_r == '0);
endmodule : ams_cnt

// [core/ams_irq.sv]
// interrupt enable masks, sticky event status and the interrupt line
module ams_irq (
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  ams_irq_if.sink i
);
  logic [1:0] mask_r;
  logic [1:0] status_r;
  logic irq_r;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      mask_r <= ams_pkg::MASK_RST;
    end else if (ce) begin
      mask_r <= (mask_r | i.set_bits) & ~i.clr_bits;
    end
  end

  // a new event beats a software acknowledge in the same cycle
  always_ff @(posedge clk) begin
    if (!resetn) begin
      status_r <= 2'h0;
    end else if (ce) begin
      status_r <= (status_r & ~i.ack_bits) | i.events;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      irq_r <= 1'b0;
    end else if (ce) begin
      irq_r <= |(status_r & mask_r);
    end
  end

  assign i.mask = mask_r;
  assign i.status = status_r;
  assign i.irq = irq_r;
endmodule : ams_irq

// [dv/ams_mem.sv]
// behavioural 8-bit async memory with an active-low wait pin
module ams_mem (
  input wire logic CLK,
  input wire logic [2:0] cs_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic [1:0] be_n,
  input wire logic [21:0] addr,
  input wire logic [1:0] ba,
  input wire logic [15:0] dout,
  input wire logic [31:0] slow,
  output logic [15:0] din,
  output logic wait_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem_r [0:4095];
  logic [11:0] ix;
  int w = 0;
  initial din = 16'h0;
  assign ix = {addr[9:0], ba};
  always @(posedge CLK) begin
    if (!we_n && !cs_n[0] && !be_n[0]) begin
      mem_r[ix] <= dout[7:0];
    end
    // a released bus keeps toggling so a stale byte never looks valid
    if (!oe_n && !cs_n[0]) begin
      din <= {8'h00, mem_r[ix]};
    end else begin
      din <= ~din;
    end
    w <= (!oe_n || !we_n) ? w + 1 : 0;
  end
  assign wait_n = !((!oe_n || !we_n) && w < slow);
endmodule : ams_mem

// [dv/ams_chk.sv]
// concurrent checks on the async memory sequencer pins
module ams_chk (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic WB_ACK_O,
  input wire logic REQ_ABORT,
  input wire logic MEM_DATA_OE,
  input wire logic [2:0] ASYNC_CHIP_SELECT_N,
  input wire logic OUTPUT_ENABLE_N,
  input wire logic WRITE_ENABLE_N,
  input wire logic [1:0] BYTE_ENABLE_N,
  input wire logic IRQ
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [12:0] stb_cnt_r;
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESETN);
  // longest strobe: 64 cycles plus the largest wait limit of 256 * 16
  always_ff @(posedge CLK) begin
    if (!RESETN || (OUTPUT_ENABLE_N && WRITE_ENABLE_N)) begin
      stb_cnt_r <= 13'h0;
    end else begin
      stb_cnt_r <= stb_cnt_r + 13'h1;
    end
  end
  property p_rd_we; !OUTPUT_ENABLE_N |-> WRITE_ENABLE_N; endproperty
  a_rd_we: assert property (p_rd_we)
    else $error("write strobe low during read");
  property p_wr_oe; MEM_DATA_OE |-> OUTPUT_ENABLE_N; endproperty
  a_wr_oe: assert property (p_wr_oe)
    else $error("output enable low during write");
  property p_stb_cs; $fell(OUTPUT_ENABLE_N) |-> $past(ASYNC_CHIP_SELECT_N) != 3'h7; endproperty
  a_stb_cs: assert property (p_stb_cs)
    else $error("strobe without select in setup");
  property p_wr_be; !WRITE_ENABLE_N |-> BYTE_ENABLE_N != 2'h3; endproperty
  a_wr_be: assert property (p_wr_be)
    else $error("write strobe without byte enable");
  property p_wr_dat; $fell(WRITE_ENABLE_N) |-> MEM_DATA_OE && $past(MEM_DATA_OE); endproperty
  a_wr_dat: assert property (p_wr_dat)
    else $error("write data not driven from setup");
  property p_abort; REQ_ABORT |-> OUTPUT_ENABLE_N && WRITE_ENABLE_N && !MEM_DATA_OE; endproperty
  a_abort: assert property (p_abort)
    else $error("abandoned request touched the bus");
  property p_mclr;
    WB_ACK_O && WB_WE_I && WB_ADR_I == ams_pkg::OFF_MCLR && WB_SEL_I[0] && WB_DAT_I[1:0] == 2'h3 |-> ##2 !IRQ;
  endproperty
  a_mclr: assert property (p_mclr)
    else $error("interrupt survives mask clear");
  property p_stb_max; stb_cnt_r <= 13'h1041; endproperty
  a_stb_max: assert property (p_stb_max)
    else $error("strobe outlived the wait limit");
endmodule : ams_chk
bind ams_top ams_chk u_ams_chk (.CLK, .RESETN, .WB_WE_I, .WB_ADR_I, .WB_SEL_I, .WB_DAT_I, .WB_ACK_O, .REQ_ABORT,
  .MEM_DATA_OE, .ASYNC_CHIP_SELECT_N, .OUTPUT_ENABLE_N, .WRITE_ENABLE_N, .BYTE_ENABLE_N, .IRQ);

// [dv/test_async_mem_normal_mode_sequencer.sv]
// self-checking bench for the async memory sequencer
module test_async_mem_normal_mode_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLK = 1'h0, RESETN = 1'h0, CE = 1'h1, WB_CYC_I = 1'h0, WB_STB_I = 1'h0, WB_WE_I = 1'h0;
  logic [7:0] WB_ADR_I = 8'h0;
  logic [3:0] WB_SEL_I = 4'h0;
  logic [31:0] WB_DAT_I = 32'h0, REQ_WDATA = 32'h0, WB_DAT_O, REQ_RDATA, q, d;
  logic WB_ACK_O, REQ_VALID = 1'h0, REQ_TOP = 1'h0, REQ_WRITE = 1'h0, REQ_TAKEN, REQ_DONE, REQ_ABORT;
  logic [1:0] REQ_CS = 2'h0, REQ_SIZE = 2'h0, MEM_BANK_ADDR_BITS, BYTE_ENABLE_N;
  logic [23:0] REQ_ADDR = 24'h0, a1, a2;
  logic [21:0] MEM_ADDR_BUS;
  logic [15:0] MEM_DATA_IN, MEM_DATA_OUT;
  logic MEM_DATA_OE, OUTPUT_ENABLE_N, WRITE_ENABLE_N, EXT_WAIT_IN, IRQ;
  logic [2:0] ASYNC_CHIP_SELECT_N;
  int n_errors = 0, samples_checked = 0, cyc = 0, slow = 0, seed = 32'hbe88;
  logic [7:0] em [int];
  always #2 CLK = ~CLK;
  always @(posedge CLK) cyc <= cyc + 1;
  ams_top u_ams_top (.CLK, .RESETN, .CE, .WB_CYC_I, .WB_STB_I, .WB_WE_I, .WB_ADR_I, .WB_SEL_I, .WB_DAT_I,
    .WB_DAT_O, .WB_ACK_O, .REQ_VALID, .REQ_TOP, .REQ_WRITE, .REQ_CS, .REQ_SIZE, .REQ_ADDR, .REQ_WDATA,
    .REQ_TAKEN, .REQ_DONE, .REQ_ABORT, .REQ_RDATA, .MEM_ADDR_BUS, .MEM_BANK_ADDR_BITS, .MEM_DATA_IN,
    .MEM_DATA_OUT, .MEM_DATA_OE, .ASYNC_CHIP_SELECT_N, .OUTPUT_ENABLE_N, .WRITE_ENABLE_N, .BYTE_ENABLE_N,
    .EXT_WAIT_IN, .IRQ);
  ams_mem u_ams_mem (.CLK, .cs_n(ASYNC_CHIP_SELECT_N), .oe_n(OUTPUT_ENABLE_N), .we_n(WRITE_ENABLE_N),
    .be_n(BYTE_ENABLE_N), .addr(MEM_ADDR_BUS), .ba(MEM_BANK_ADDR_BITS), .dout(MEM_DATA_OUT), .slow,
    .din(MEM_DATA_IN), .wait_n(EXT_WAIT_IN));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task wb(input logic we, input logic [7:0] a, input logic [31:0] dt);
    @(posedge CLK);
    WB_CYC_I <= 1'h1;
    WB_STB_I <= 1'h1;
    WB_WE_I <= we;
    WB_ADR_I <= a;
    WB_DAT_I <= dt;
    WB_SEL_I <= 4'hF;
    do @(posedge CLK);
    while (WB_ACK_O !== 1'h1);
    q = WB_DAT_O;
    WB_CYC_I <= 1'h0;
    WB_STB_I <= 1'h0;
  endtask : wb
  // turn < 0 skips the cycle count; ab drops priority after the take to force an abandon
  task acc(input logic we, input logic [1:0] sz, input logic [23:0] ad, input int turn, input bit ab);
    int t0;
    int nb;
    logic [31:0] e, m;
    nb = 1 << sz;
    d = $random(seed);
    e = 32'h0;
    m = 32'h0;
    @(posedge CLK);
    REQ_VALID <= 1'h1;
    REQ_TOP <= 1'h1;
    REQ_WRITE <= we;
    REQ_SIZE <= sz;
    REQ_ADDR <= ad;
    REQ_WDATA <= d;
    do @(posedge CLK);
    while (REQ_TAKEN !== 1'h1);
    t0 = cyc;
    REQ_VALID <= 1'h0;
    REQ_TOP <= !ab;
    do @(posedge CLK);
    while ((ab ? REQ_ABORT : REQ_DONE) !== 1'h1);
    if (ab) begin
      chk(cyc - t0 < 20, 32'h1);
      REQ_TOP <= 1'h1;
      return;
    end
    if (turn >= 0) chk(cyc - t0, turn + nb * (we ? 5 : 4));
    for (int i = 0; i < nb; i++) begin
      if (we) em[ad + i] = d[8 * ((ad + i) % 4) +: 8];
      else begin
        e[8 * ((ad + i) % 4) +: 8] = em[ad + i];
        m[8 * ((ad + i) % 4) +: 8] = 8'hFF;
      end
    end
    if (!we) chk(REQ_RDATA & m, e);
  endtask : acc
  task stop_test();
    $display("checked %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : stop_test
  initial begin
    repeat (20000) @(posedge CLK);
    n_errors++;
    stop_test();
  end
  initial begin
    repeat (5) @(posedge CLK);
    RESETN <= 1'h1;
    wb(1'h0, ams_pkg::OFF_CFG0, 32'h0);
    chk(q, ams_pkg::CFG_RST);
    wb(1'h0, ams_pkg::OFF_WAIT, 32'h0);
    chk(q, {23'h0, ams_pkg::WAIT_RST});
    wb(1'h0, 8'h40, 32'h0);
    chk(q, 32'h0);
    wb(1'h0, ams_pkg::OFF_STAT, 32'h0);
    chk(q, 32'h0);
    wb(1'h1, ams_pkg::OFF_MSET, 32'h3);
    wb(1'h0, ams_pkg::OFF_MCLR, 32'h0);
    chk(q, 32'h3);
    wb(1'h1, ams_pkg::OFF_MCLR, 32'h1);
    wb(1'h0, ams_pkg::OFF_MSET, 32'h0);
    chk(q, 32'h2);
    wb(1'h1, ams_pkg::OFF_MCLR, 32'h2);
    wb(1'h0, ams_pkg::OFF_MSET, 32'h0);
    chk(q, 32'h0);
    $display("register test done");
    // 8-bit device, extended wait on, read 1/2/1, write 3/1/1, turnaround field 2
    wb(1'h1, ams_pkg::OFF_CFG0, 32'h8004_0104);
    a1 = 24'($random(seed)) & 24'h0001FC;
    a2 = a1 | 24'h000200;
    acc(1'h1, ams_pkg::SZ_WORD, a1, 2, 1'h0);
    acc(1'h1, ams_pkg::SZ_WORD, a2, 0, 1'h0);
    acc(1'h0, ams_pkg::SZ_WORD, a1, 2, 1'h0);
    acc(1'h0, ams_pkg::SZ_BYTE, a2 + 24'h3, 0, 1'h0);
    wb(1'h1, ams_pkg::OFF_CFG0, 32'h0004_0104);
    acc(1'h1, ams_pkg::SZ_HALF, a2, 1, 1'h0);
    acc(1'h0, ams_pkg::SZ_WORD, a2, 1, 1'h0);
    $display("access test done");
    slow <= 5;
    acc(1'h0, ams_pkg::SZ_WORD, a1, -1, 1'h0);
    wb(1'h1, ams_pkg::OFF_WAIT, 32'h0);
    wb(1'h1, ams_pkg::OFF_MSET, 32'h3);
    slow <= 100;
    acc(1'h0, ams_pkg::SZ_BYTE, a1, -1, 1'h0);
    slow <= 0;
    repeat (3) @(posedge CLK);
    chk({31'h0, IRQ}, 32'h1);
    wb(1'h0, ams_pkg::OFF_STAT, 32'h0);
    chk(q, 32'h3);
    wb(1'h1, ams_pkg::OFF_MCLR, 32'h3);
    repeat (3) @(posedge CLK);
    chk({31'h0, IRQ}, 32'h0);
    wb(1'h1, ams_pkg::OFF_STAT, 32'h3);
    wb(1'h0, ams_pkg::OFF_STAT, 32'h0);
    chk(q, 32'h0);
    $display("wait test done");
    wb(1'h1, ams_pkg::OFF_CFG0, 32'hC004_0104);
    acc(1'h1, ams_pkg::SZ_WORD, a1, -1, 1'h1);
    acc(1'h0, ams_pkg::SZ_WORD, a1, 0, 1'h0);
    $display("abort test done");
    stop_test();
  end
endmodule : test_async_mem_normal_mode_sequencer
